// >>> hw/sci_chan_pkg.sv
// constants for the multimode serial channel clocking block
package sci_chan_pkg;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_MODE      = 8'h00;
  localparam logic [7:0] OFF_CTRL      = 8'h04;
  localparam logic [7:0] OFF_SMART_CARD_MODE_REG      = 8'h08;
  localparam logic [7:0] OFF_MODULATION_DUTY_REG      = 8'h0C;
  localparam logic [7:0] OFF_EXTMODE   = 8'h10;
  localparam logic [7:0] OFF_CMPDATA   = 8'h14;
  localparam logic [7:0] OFF_CMPCTRL   = 8'h18;
  localparam logic [7:0] OFF_PORTMON   = 8'h1C;
  localparam logic [7:0] OFF_TIMING    = 8'h20;
  localparam logic [7:0] OFF_COLLCLK   = 8'h24;
  localparam logic [7:0] OFF_TX_HIGH   = 8'h28;
  localparam logic [7:0] OFF_TX_LOW    = 8'h2C;
  localparam logic [7:0] OFF_TX_COMB   = 8'h30;
  localparam logic [7:0] OFF_RX_HIGH   = 8'h34;
  localparam logic [7:0] OFF_RX_LOW    = 8'h38;
  localparam logic [7:0] OFF_RX_COMB   = 8'h3C;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h40;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h44;
  localparam logic [7:0] OFF_IRQ_CLR   = 8'h48;
  localparam logic [7:0] OFF_STATUS    = 8'h4C;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int MODE_CHR_POS   = 6;  // char_length_bit
  localparam int MODE_CKS_LO    = 0;  // clock_prescaler_field
  localparam int MODE_SEL_LO    = 2;  // operating mode select (3 bits)
  localparam int CTRL_CKE_LO    = 0;
  localparam int SMART_CARD_MODE_REG_SMART_CARD_INTERFACE_SELECT_POS  = 0;
  localparam int SMART_CARD_MODE_REG_CHAR_LENGTH_EXT_BIT_POS  = 4;  // char_length_ext_bit
  localparam int EXT_ASYNC_CLOCK_SOURCE_SELECT_POS   = 0;
  localparam int EXT_BASIC_CLOCK_SELECT_POS   = 4;
  localparam int EXT_DOUBLE_SPEED_SELECT_POS   = 6;
  localparam int CMP_EN_POS     = 0;
  localparam int COLL_BCCS_LO   = 4;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0]  RST_MODE  = 8'h00;
  localparam logic [7:0]  RST_CTRL  = 8'h00;
  localparam logic [7:0]  RST_SMART_CARD_MODE_REG  = 8'hF2;  // ext length bit set: 8-bit
  localparam logic [7:0]  RST_MODULATION_DUTY_REG  = 8'hFF;
  localparam logic [7:0]  RST_EXT   = 8'h00;
  localparam logic [15:0] RST_CMP   = 16'h0000;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [7:0]  RST_COLL  = 8'h00;  // a permitted setting
  // ************************************************************
  // channel features and modes
  // ************************************************************
  localparam int NUM_IRQ = 2;
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_RXFULL = 1;
  typedef enum logic [2:0] {
    MODE_ASYNC = 3'd0, MODE_SYNC = 3'd1, MODE_SCARD = 3'd2,
    MODE_I2C   = 3'd3, MODE_SPI  = 3'd4
  } op_mode_e;
  typedef enum logic [2:0] {
    CLK_BRG = 3'b001, CLK_EXT = 3'b010, CLK_TMR = 3'b100
  } clk_src_e;
endpackage

// >>> hw/sci_chan.sv
// serial channel clock selection, length decode and register file
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module sci_chan
  import sci_chan_pkg::*;
#(
  parameter bit       HAS_TMR_CLK   = 1'b1,
  parameter bit       HAS_MATCH     = 1'b1,
  parameter bit [1:0] TMR_SEL_A     = 2'd0,
  parameter bit [1:0] TMR_SEL_B     = 2'd1
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // serial clock pin
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_out,
  // timer compare-match sources
  input  wire logic [3:0]  tmr_match_in,
  // received character from the shifter
  input  wire logic        rx_valid_in,
  input  wire logic [8:0]  rx_data_in,
  // status towards the shifter
  output logic [3:0]       char_bits_out,
  output logic             bit_tick_out,
  output logic             coll_tick_out,
  output logic [8:0]       tx_data_out,
  // interrupt
  output logic             irq_out
);
  import sci_chan_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0]  mode_q, ctrl_q, smart_card_mode_reg_q, modulation_duty_reg_q, ext_q, cmpctl_q, portmon_q;
  logic [7:0]  timing_q, coll_q, irq_en_q;
  logic [15:0] cmp_q;
  logic [8:0]  tx_q, rx_q;
  logic [NUM_IRQ-1:0] irq_stat_q;
  logic        wr_en, rd_en;
  logic [31:0] rdata_d;
  op_mode_e    op_mode;

  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && !penable_in && !pwrite_in;

  function automatic logic [3:0] char_len(input logic ext, input logic chr,
                                          input op_mode_e m);
    if (m != MODE_ASYNC) return 4'd8;
    unique case ({ext, chr})
      2'b10:   return 4'd8;
      2'b11:   return 4'd7;
      default: return 4'd9;
    endcase
  endfunction

  always_comb begin
    unique case (mode_q[MODE_SEL_LO +: 3])
      3'd1:    op_mode = MODE_SYNC;
      3'd2:    op_mode = MODE_SCARD;
      3'd3:    op_mode = MODE_I2C;
      3'd4:    op_mode = MODE_SPI;
      default: op_mode = MODE_ASYNC;
    endcase
  end

  // ************************************************************
  // register writes
  // ************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q    <= RST_MODE;
      ctrl_q    <= RST_CTRL;
      smart_card_mode_reg_q    <= RST_SMART_CARD_MODE_REG;
      modulation_duty_reg_q    <= RST_MODULATION_DUTY_REG;
      ext_q     <= RST_EXT;
      cmp_q     <= RST_CMP;
      cmpctl_q  <= RST_BYTE;
      portmon_q <= RST_BYTE;
      timing_q  <= RST_BYTE;
      coll_q    <= RST_COLL;
      irq_en_q  <= RST_BYTE;
      tx_q      <= 9'h000;
    end else if (wr_en) begin
      unique case (paddr_in)
        OFF_MODE:    mode_q    <= pwdata_in[7:0];
        OFF_CTRL:    ctrl_q    <= pwdata_in[7:0];
        OFF_SMART_CARD_MODE_REG:    smart_card_mode_reg_q    <= pwdata_in[7:0];
        OFF_MODULATION_DUTY_REG:    modulation_duty_reg_q    <= pwdata_in[7:0];
        OFF_EXTMODE: ext_q     <= pwdata_in[7:0];
        OFF_CMPDATA: cmp_q     <= pwdata_in[15:0];
        OFF_CMPCTRL: cmpctl_q  <= pwdata_in[7:0];
        OFF_PORTMON: portmon_q <= pwdata_in[7:0];
        OFF_TIMING:  timing_q  <= pwdata_in[7:0];
        OFF_COLLCLK: coll_q    <= pwdata_in[7:0];
        OFF_IRQ_EN:  irq_en_q  <= pwdata_in[7:0];
        OFF_TX_HIGH: tx_q[8]   <= pwdata_in[0];
        OFF_TX_LOW:  tx_q[7:0] <= pwdata_in[7:0];
        OFF_TX_COMB: tx_q      <= pwdata_in[8:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // receive capture and interrupts
  // ************************************************************
  logic match_ev;
  assign match_ev = HAS_MATCH && cmpctl_q[CMP_EN_POS] && rx_valid_in
                    && (rx_data_in == cmp_q[8:0]);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      rx_q <= 9'h000;
    else if (rx_valid_in)
      rx_q <= rx_data_in;
  end

  // set wins over clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_q <= '0;
    end else begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        if ((i == IRQ_MATCH && match_ev) || (i == IRQ_RXFULL && rx_valid_in))
          irq_stat_q[i] <= 1'b1;
        else if (wr_en && paddr_in == OFF_IRQ_CLR && pwdata_in[i])
          irq_stat_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(irq_stat_q & irq_en_q[NUM_IRQ-1:0]);
  end

  // ************************************************************
  // apb read path
  // ************************************************************
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr_in)
      OFF_MODE:     rdata_d[7:0]  = mode_q;
      OFF_CTRL:     rdata_d[7:0]  = ctrl_q;
      OFF_SMART_CARD_MODE_REG:     rdata_d[7:0]  = smart_card_mode_reg_q;
      OFF_MODULATION_DUTY_REG:     rdata_d[7:0]  = modulation_duty_reg_q;
      OFF_EXTMODE:  rdata_d[7:0]  = ext_q;
      OFF_CMPDATA:  rdata_d[15:0] = cmp_q;
      OFF_CMPCTRL:  rdata_d[7:0]  = cmpctl_q;
      OFF_PORTMON:  rdata_d[7:0]  = {portmon_q[7:1], sck_in};
      OFF_TIMING:   rdata_d[7:0]  = timing_q;
      OFF_COLLCLK:  rdata_d[7:0]  = coll_q;
      OFF_TX_HIGH:  rdata_d[0]    = tx_q[8];
      OFF_TX_LOW:   rdata_d[7:0]  = tx_q[7:0];
      OFF_TX_COMB:  rdata_d[8:0]  = tx_q;
      OFF_RX_HIGH:  rdata_d[0]    = rx_q[8];
      OFF_RX_LOW:   rdata_d[7:0]  = rx_q[7:0];
      OFF_RX_COMB:  rdata_d[8:0]  = rx_q;
      OFF_IRQ_STAT: rdata_d[NUM_IRQ-1:0] = irq_stat_q;
      OFF_IRQ_EN:   rdata_d[7:0]  = irq_en_q;
      OFF_STATUS:   rdata_d[7:0]  = {char_bits_out, 1'b0, op_mode};
      default:      rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= 1'b0;
      if (rd_en)
        prdata_out <= rdata_d;
    end
  end

  // ************************************************************
  // baud generator, peripheral bus clock domain
  // ************************************************************
  logic [1:0]  cks;
  logic [1:0]  cke;
  logic        double_speed_select, basic_clock_select, async_clock_source_select, is_async;
  logic [13:0] brg_cnt_q;
  logic [13:0] brg_lim;
  logic [13:0] brg_full;
  logic        brg_tick;
  assign cks      = mode_q[MODE_CKS_LO +: 2];
  assign cke      = ctrl_q[CTRL_CKE_LO +: 2];
  assign double_speed_select     = ext_q[EXT_DOUBLE_SPEED_SELECT_POS];
  assign basic_clock_select     = ext_q[EXT_BASIC_CLOCK_SELECT_POS];
  assign async_clock_source_select     = ext_q[EXT_ASYNC_CLOCK_SOURCE_SELECT_POS];
  assign is_async = (op_mode == MODE_ASYNC) && !smart_card_mode_reg_q[SMART_CARD_MODE_REG_SMART_CARD_INTERFACE_SELECT_POS];
  // divide by (modulation_duty_reg << 2*cks) + 1, the shifted value halved in double speed
  // full width keeps the largest prescale shift from wrapping
  assign brg_full = 14'({6'd0, modulation_duty_reg_q}) << (2 * cks);
  assign brg_lim  = double_speed_select ? brg_full >> 1 : brg_full;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      brg_cnt_q <= 14'd0;
    else if (brg_cnt_q >= brg_lim)
      brg_cnt_q <= 14'd0;
    else
      brg_cnt_q <= brg_cnt_q + 14'd1;
  end
  assign brg_tick = (brg_cnt_q >= brg_lim);

  // ************************************************************
  // clock source selection and pin direction
  // ************************************************************
  clk_src_e    src;
  logic        tmr_clk, sck_prev_q, ext_edge, base_tick;
  assign tmr_clk  = tmr_match_in[TMR_SEL_A] & tmr_match_in[TMR_SEL_B];
  always_comb begin
    if (!cke[1])
      src = CLK_BRG;
    else if (is_async && async_clock_source_select && HAS_TMR_CLK)
      src = CLK_TMR;
    else
      src = CLK_EXT;
  end

  logic ext_lvl;
  assign ext_lvl = (src == CLK_TMR) ? tmr_clk : sck_in;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      sck_prev_q <= 1'b1;  // pin idles high: no false edge after reset
    else
      sck_prev_q <= ext_lvl;
  end
  // external clock already runs at 16x or 8x in async, 2x when not async; each rising edge is one base tick
  assign ext_edge  = ext_lvl && !sck_prev_q;
  assign base_tick = (src == CLK_BRG) ? brg_tick : ext_edge;

  // bit clock: base/16, or base/8 with basic clock select, in async; base/2 when not async
  logic [3:0] os_cnt_q;
  logic [3:0] os_lim;
  logic       bit_end;
  assign os_lim  = (is_async && !basic_clock_select) ? 4'd15 : (is_async ? 4'd7 : 4'd1);
  assign bit_end = base_tick && (os_cnt_q >= os_lim);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      os_cnt_q <= 4'd0;
    else if (bit_end)
      os_cnt_q <= 4'd0;
    else if (base_tick)
      os_cnt_q <= os_cnt_q + 4'd1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_out    <= 1'b0;
      sck_oe_out <= 1'b0;
    end else begin
      if (is_async)
        sck_oe_out <= (src == CLK_BRG) && cke[0];
      else
        sck_oe_out <= !cke[1];
      if (base_tick && os_cnt_q == (os_lim >> 1))
        sck_out <= 1'b1;
      else if (bit_end)
        sck_out <= 1'b0;
    end
  end

  // ************************************************************
  // collision clock divider
  // ************************************************************
  logic [1:0] bccs;
  logic [2:0] coll_div;
  logic [1:0] coll_cnt_q;
  assign bccs = coll_q[COLL_BCCS_LO +: 2];
  always_comb begin
    if (double_speed_select && cks == 2'b00)
      coll_div = (bccs == 2'b00) ? 3'd2 : 3'd4;
    else
      coll_div = (bccs == 2'b00) ? 3'd1 : (bccs == 2'b01 ? 3'd2 : 3'd4);
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      coll_cnt_q    <= 2'd0;
      coll_tick_out <= 1'b0;
    end else begin
      coll_tick_out <= 1'b0;
      if (base_tick) begin
        if ({1'b0, coll_cnt_q} >= coll_div - 3'd1) begin
          coll_cnt_q    <= 2'd0;
          coll_tick_out <= 1'b1;
        end else begin
          coll_cnt_q <= coll_cnt_q + 2'd1;
        end
      end
    end
  end

  // ************************************************************
  // shifter-facing outputs
  // ************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      char_bits_out <= 4'd8;
      bit_tick_out  <= 1'b0;
      tx_data_out   <= 9'h000;
    end else begin
      char_bits_out <= char_len(smart_card_mode_reg_q[SMART_CARD_MODE_REG_CHAR_LENGTH_EXT_BIT_POS], mode_q[MODE_CHR_POS], op_mode);
      bit_tick_out  <= bit_end;
      tx_data_out   <= tx_q;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_len_async: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (op_mode == MODE_ASYNC && smart_card_mode_reg_q[SMART_CARD_MODE_REG_CHAR_LENGTH_EXT_BIT_POS] && mode_q[MODE_CHR_POS])
    |=> char_bits_out == 4'd7) else $error("async length 11 not 7 bits");
  chk_len_sync: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (op_mode != MODE_ASYNC) |=> char_bits_out == 4'd8)
    else $error("non-async length not 8 bits");
  chk_pin_float: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (is_async && cke == 2'b00) |=> !sck_oe_out) else $error("clock pin driven in async 00");
  chk_pin_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (is_async && cke == 2'b01) |=> sck_oe_out) else $error("clock pin idle in async 01");
  chk_tmr_float: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (src == CLK_TMR) |=> !sck_oe_out) else $error("clock pin driven on timer clock");
  chk_sync_dir: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (op_mode == MODE_SYNC) |=> sck_oe_out == !$past(cke[1]))
    else $error("sync clock pin direction wrong");
  chk_irq_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    match_ev && irq_en_q[IRQ_MATCH] |-> ##2 irq_out) else $error("match irq missing");
  chk_coll_dbl: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (double_speed_select && cks == 2'b00) |-> coll_div != 3'd1) else $error("double speed collision /1");
  sequence coll_restart_s;
    double_speed_select && cks == 2'b00 && base_tick && coll_cnt_q == 2'd0;
  endsequence
  chk_coll_skip: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    coll_restart_s |=> !coll_tick_out) else $error("double speed collision tick too soon");
endmodule // sci_chan

// >>> bench/serial_peer.sv
// serial peer model: external clock source and received character feed
`timescale 1ns/1ps
module serial_peer (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // external clock control
  input  wire logic       run_in,
  input  wire logic [3:0] half_in,
  // clock pin as driven by the channel
  input  wire logic       sck_drv_in,
  input  wire logic       sck_oe_in,
  // character feed
  input  wire logic       send_in,
  input  wire logic [8:0] data_in,
  output logic            sck_line_out,
  output logic            rx_valid_out,
  output logic [8:0]      rx_data_out
);
  // ************************************************************
  // clock pin and character feed
  // ************************************************************
  logic [3:0] cnt_q;
  logic       ext_q;
  // clock at 16x or 8x the bit rate, standing high between bursts
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 4'h0;
      ext_q <= 1'b1;
    end else if (!run_in) begin
      cnt_q <= 4'h0;
      ext_q <= 1'b1;
    end else if (cnt_q + 4'h1 >= half_in) begin
      cnt_q <= 4'h0;
      ext_q <= ~ext_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign sck_line_out = sck_oe_in ? sck_drv_in : ext_q;
  // a character stands one cycle, then the lines show a changing pattern
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_valid_out <= 1'b0;
      rx_data_out  <= 9'h000;
    end else begin
      rx_valid_out <= send_in;
      rx_data_out  <= send_in ? data_in : ~rx_data_out;
    end
  end
endmodule // serial_peer

// >>> bench/multimode_serial_channel_clocking_tb.sv
// self-checking bench for the serial channel clocking block
`timescale 1ns/1ps
module multimode_serial_channel_clocking_tb;
  import sci_chan_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, r;
  logic        sck_line, sck_out, sck_oe_out, sck_prev, tmr_run, run, send, rx_valid;
  logic        bit_tick_out, coll_tick_out, irq_out;
  logic [3:0]  tmr, tmr_pat, half, char_bits_out;
  logic [8:0]  rx_data, send_d, tx_data_out, d;
  int          bad_count, samples_checked, cyc, ticks, colls, rises, dt, dc, dr;
  integer      seed;

  always #2.5 clk_in = ~clk_in;

  sci_chan dut (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .sck_in(sck_line), .sck_out,
    .sck_oe_out, .tmr_match_in(tmr), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
    .char_bits_out, .bit_tick_out, .coll_tick_out, .tx_data_out, .irq_out);
  serial_peer peer (.clk_in, .rst_n_in, .run_in(run), .half_in(half), .sck_drv_in(sck_out),
    .sck_oe_in(sck_oe_out), .send_in(send), .data_in(send_d), .sck_line_out(sck_line),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data));

  // ************************************************************
  // counters, timeout and helpers
  // ************************************************************
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    sck_prev <= sck_out;
    if (bit_tick_out === 1'b1) ticks <= ticks + 1;
    if (coll_tick_out === 1'b1) colls <= colls + 1;
    if (sck_out === 1'b1 && sck_prev === 1'b0) rises <= rises + 1;
    tmr <= (tmr_run && cyc[1]) ? tmr_pat : 4'h0;
    if (cyc == 30000) begin
      bad_count++;
      summarize();
    end
  end
  task summarize;
    $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task near(input int seen, input int exp);
    check(32'(seen >= exp - 1 && seen <= exp + 1), 32'h0000_0001);
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    check(pready_out, 32'h0000_0001);
    check(pslverr_out, 32'h0000_0000);
    r = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(r, e);
  endtask
  task span(input int n);
    int t0, c0, s0;
    t0 = ticks;
    c0 = colls;
    s0 = rises;
    repeat (n) @(posedge clk_in);
    dt = ticks - t0;
    dc = colls - c0;
    dr = rises - s0;
  endtask
  task push(input logic [8:0] v);
    send <= 1'b1;
    send_d <= v;
    @(posedge clk_in);
    send <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  function int base(input int m, input int cks, input int ds);
    return ((m << (2 * cks)) >> ds) + 1;
  endfunction
  function int cdiv(input int ds, input int cks, input int b);
    if (ds != 0 && cks == 0) return (b == 0) ? 2 : 4;
    return (b == 0) ? 1 : (b == 1) ? 2 : 4;
  endfunction

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    seed = 32'h0000_b07b;
    {rst_n_in, psel_in, penable_in, pwrite_in, run, send, tmr_run} <= 7'h00;
    {paddr_in, pwdata_in, send_d, tmr_pat} <= '0;
    half <= 4'h2;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    check(char_bits_out, 8);
    rd(OFF_SMART_CARD_MODE_REG, 32'h0000_00F2);
    rd(OFF_COLLCLK, 32'h0000_0000);
    rd(OFF_STATUS, 32'h0000_0080);
    rd(OFF_MODULATION_DUTY_REG, 32'h0000_00FF);
    rd(8'h50, 32'h0000_0000);
    wr(8'h50, 32'hFFFF_FFFF);
    rd(8'h50, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_SMART_CARD_MODE_REG, i[1] ? 32'h0000_00F2 : 32'h0000_00E2);
      wr(OFF_MODE, 32'(i[0]) << MODE_CHR_POS);
      rd(OFF_STATUS, 32'((i < 2) ? 9 : 10 - i) << 4);
      check(char_bits_out, (i < 2) ? 9 : 10 - i);
    end
    for (int m = 1; m < 5; m++) begin
      wr(OFF_MODE, 32'h0000_0040 | (m << MODE_SEL_LO));
      rd(OFF_STATUS, 32'h0000_0080 | m);
      check(char_bits_out, 8);
    end
    for (int k = 0; k < 8; k++) begin
      wr(OFF_MODE, (k >> 2) << MODE_SEL_LO);
      wr(OFF_CTRL, k & 3);
      repeat (3) @(posedge clk_in);
      check(sck_oe_out, (k >> 2) ? !k[1] : (k == 1));
    end
    wr(OFF_MODE, 0);
    wr(OFF_CTRL, 2);
    for (int a = 0; a < 2; a++) begin
      wr(OFF_EXTMODE, a << EXT_BASIC_CLOCK_SELECT_POS);
      run <= 1'b1;
      span(256);
      near(dt, a ? 8 : 4);
      run <= 1'b0;
    end
    wr(OFF_EXTMODE, 1 << EXT_ASYNC_CLOCK_SOURCE_SELECT_POS);
    tmr_run <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      tmr_pat <= p ? 4'h3 : 4'hD;
      repeat (4) @(posedge clk_in);
      span(256);
      near(dt, p ? 4 : 0);
      check(sck_oe_out, 0);
    end
    tmr_run <= 1'b0;
    wr(OFF_MODULATION_DUTY_REG, 3);
    wr(OFF_CTRL, 1);
    for (int c = 0; c < 12; c++) begin
      wr(OFF_MODE, c >= 8);
      wr(OFF_EXTMODE, (c >= 4) << EXT_DOUBLE_SPEED_SELECT_POS);
      wr(OFF_COLLCLK, (c & 3) << COLL_BCCS_LO);
      repeat (8) @(posedge clk_in);
      span(640);
      near(dc, 640 / (base(3, c >= 8, c >= 4) * cdiv(c >= 4, c >= 8, c & 3)));
      near(dt, 640 / (16 * base(3, c >= 8, c >= 4)));
      near(dr, dt);
    end
    wr(OFF_IRQ_EN, 2);
    d = 9'($random(seed));
    push(d);
    check(irq_out, 1);
    rd(OFF_RX_HIGH, d[8]);
    rd(OFF_RX_LOW, d[7:0]);
    rd(OFF_RX_COMB, d);
    wr(OFF_IRQ_EN, 0);
    wr(OFF_IRQ_STAT, 0);
    check(irq_out, 0);
    rd(OFF_IRQ_STAT, 2);
    wr(OFF_IRQ_CLR, 2);
    rd(OFF_IRQ_STAT, 0);
    wr(OFF_CMPDATA, d);
    wr(OFF_CMPCTRL, 1);
    wr(OFF_IRQ_EN, 1);
    push(d);
    check(irq_out, 1);
    rd(OFF_IRQ_STAT, 3);
    wr(OFF_IRQ_CLR, 3);
    push(d ^ 9'h001);
    rd(OFF_IRQ_STAT, 2);
    check(irq_out, 0);
    d = 9'($random(seed));
    wr(OFF_TX_COMB, d);
    @(posedge clk_in);
    check(tx_data_out, d);
    rd(OFF_TX_HIGH, d[8]);
    rd(OFF_TX_LOW, d[7:0]);
    d = 9'($random(seed));
    wr(OFF_TX_LOW, d[7:0]);
    wr(OFF_TX_HIGH, d[8]);
    rd(OFF_TX_COMB, d);
    check(tx_data_out, d);
    summarize();
  end
endmodule // multimode_serial_channel_clocking_tb
